// file: disk_port_pkg.sv
// Constants and carrier types for the disk controller host port.
// Assumes byte-wide I/O at four consecutive port locations.
package disk_port_pkg;

  // ==========================================================
  // Port locations
  localparam logic [9:0] PORT_DATA   = 10'h320;
  localparam logic [9:0] PORT_STATUS = 10'h321;
  localparam logic [9:0] PORT_CONFIG = 10'h322;
  localparam logic [9:0] PORT_MASK   = 10'h323;

  // ==========================================================
  // Field positions
  localparam int ST_IRQ  = 5;
  localparam int ST_DMA  = 4;
  localparam int ST_BUSY = 3;
  localparam int ST_CD   = 2;
  localparam int ST_IO   = 1;
  localparam int ST_REQ  = 0;
  localparam int MK_IRQ  = 1;
  localparam int MK_DMA  = 0;
  localparam int CB_LUN  = 5;
  localparam int CB_ERR  = 1;

  // ==========================================================
  // Fixed values
  localparam logic [1:0] STATUS_ONES = 2'h3;
  localparam logic [3:0] CONFIG_ONES = 4'hF;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [3:0] CMD_LEN_SHORT = 4'h6;
  localparam logic [3:0] CMD_LEN_LONG  = 4'hA;
  localparam logic [2:0] LONG_CLASS    = 3'h1;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_IDLE   = 3'b001,
    ST_SELECT = 3'b010,
    ST_CMD    = 3'b011,
    ST_DATA   = 3'b100,
    ST_STAT   = 3'b101
  } phase_e;

  // Host bus access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  // Back-end job description
  typedef struct packed {
    logic        to_host;
    logic [15:0] count;
    logic        lun;
    logic        error;
  } job_s;

endpackage

// file: byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_srst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: disk_ctrl_host_port.sv
// Host port of the disk controller: four byte ports, handshake status,
// six-phase sequencer, PIO and DMA byte moves, completion byte.
// Assumes bus strobes are single-cycle and synchronous to i_ref_clk.
module disk_ctrl_host_port #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_srst,
  // Host I/O bus
  input  wire disk_port_pkg::host_req_s i_host,
  output logic [7:0]                  o_rdata,
  // DMA handshake and interrupt
  output logic                        o_drq,
  input  wire logic                   i_dack,
  input  wire logic [7:0]             i_dma_wdata,
  output logic                        o_irq,
  // Drive jumpers
  input  wire logic [3:0]             i_config_jumper,
  // Back end: job from command decoder
  input  wire logic                   i_job_valid,
  input  wire disk_port_pkg::job_s    i_job,
  // Back end: command bytes out
  output logic                        o_cmd_valid,
  output logic [7:0]                  o_cmd_byte,
  // Back end: host-to-device data
  output logic                        o_wr_valid,
  output logic [7:0]                  o_wr_data,
  input  wire logic                   i_wr_ready,
  // Back end: device-to-host data
  input  wire logic                   i_rd_valid,
  input  wire logic [7:0]             i_rd_data,
  output logic                        o_rd_ready,
  // Phase view
  output disk_port_pkg::phase_e       o_phase
);

  // ==========================================================
  // Decode
  logic       reset_hit;
  logic       select_hit;
  logic       data_wr;
  logic       data_rd;
  logic       mask_wr;
  logic       dack_hit;
  logic       byte_done;

  assign reset_hit  = i_host.wr && (i_host.addr == disk_port_pkg::PORT_STATUS);
  assign select_hit = i_host.wr && (i_host.addr == disk_port_pkg::PORT_CONFIG);
  assign data_wr    = i_host.wr && (i_host.addr == disk_port_pkg::PORT_DATA);
  assign data_rd    = i_host.rd && (i_host.addr == disk_port_pkg::PORT_DATA);
  assign mask_wr    = i_host.wr && (i_host.addr == disk_port_pkg::PORT_MASK);

  // ==========================================================
  // State
  disk_port_pkg::phase_e phase_r;
  logic [7:0]  mask_r;
  logic        busy_r;
  logic        cd_r;
  logic        io_r;
  logic        req_r;
  logic        irq_r;
  logic        drq_r;
  logic [3:0]  cmd_cnt_r;
  logic [3:0]  cmd_len_r;
  logic [15:0] data_cnt_r;
  logic [7:0]  data_in_r;
  logic        lun_r;
  logic        err_r;
  logic        job_wait_r;
  logic [7:0]  cmd_byte_r;
  logic        cmd_valid_r;
  logic [7:0]  rdata_r;

  wire soft_reset = i_srst || reset_hit;
  wire dma_mode   = mask_r[disk_port_pkg::MK_DMA];
  wire irq_en     = mask_r[disk_port_pkg::MK_IRQ];

  // Fifo toward back end for host-to-device data
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [7:0] fifo_in_data;

  assign dack_hit  = drq_r && i_dack;
  assign byte_done = dma_mode ? dack_hit : (req_r && (io_r ? data_rd : data_wr));
  assign fifo_in_valid = (phase_r == disk_port_pkg::ST_DATA) && !io_r && byte_done;
  assign fifo_in_data  = dma_mode ? i_dma_wdata : i_host.wdata;
  assign o_rd_ready    = (phase_r == disk_port_pkg::ST_DATA) && io_r && byte_done;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (soft_reset),
    .i_in_valid  (fifo_in_valid),
    .i_in_data   (fifo_in_data),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_wr_valid),
    .o_out_data  (o_wr_data),
    .i_out_ready (i_wr_ready)
  );
  // Byte is ready to move: fifo space for writes, source data for reads
  wire data_avail = io_r ? i_rd_valid : fifo_in_ready;

  // ==========================================================
  // Mask register
  always_ff @(posedge i_ref_clk)
  begin
    if (soft_reset)
    begin
      mask_r <= disk_port_pkg::MASK_RESET;
    end
    else if (mask_wr)
    begin
      mask_r <= i_host.wdata;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_ref_clk)
  begin
    if (soft_reset)
    begin
      phase_r    <= disk_port_pkg::ST_RESET;
      cmd_cnt_r  <= '0;
      cmd_len_r  <= disk_port_pkg::CMD_LEN_SHORT;
      data_cnt_r <= '0;
      job_wait_r <= 1'b0;
      lun_r      <= 1'b0;
      err_r      <= 1'b0;
    end
    else
    begin
      case (phase_r)
        disk_port_pkg::ST_RESET:
        begin
          phase_r <= disk_port_pkg::ST_IDLE;
        end
        disk_port_pkg::ST_IDLE:
        begin
          if (select_hit)
          begin
            phase_r <= disk_port_pkg::ST_SELECT;
          end
        end
        disk_port_pkg::ST_SELECT:
        begin
          cmd_cnt_r <= '0;
          phase_r   <= disk_port_pkg::ST_CMD;
        end
        disk_port_pkg::ST_CMD:
        begin
          if (req_r && data_wr)
          begin
            // First byte's class picks descriptor length
            if (cmd_cnt_r == '0)
            begin
              cmd_len_r <= (i_host.wdata[7:5] == disk_port_pkg::LONG_CLASS) ?
                           disk_port_pkg::CMD_LEN_LONG : disk_port_pkg::CMD_LEN_SHORT;
            end
            cmd_cnt_r <= cmd_cnt_r + 4'h1;
            if ((cmd_cnt_r != '0) && (cmd_cnt_r + 4'h1 == cmd_len_r))
            begin
              job_wait_r <= 1'b1;
            end
          end
          if (job_wait_r && i_job_valid)
          begin
            job_wait_r <= 1'b0;
            lun_r      <= i_job.lun;
            err_r      <= i_job.error;
            data_cnt_r <= i_job.count;
            phase_r    <= (i_job.count == '0) ? disk_port_pkg::ST_STAT
                                              : disk_port_pkg::ST_DATA;
          end
        end
        disk_port_pkg::ST_DATA:
        begin
          if (byte_done)
          begin
            data_cnt_r <= data_cnt_r - 16'h1;
            if (data_cnt_r == 16'h1)
            begin
              phase_r <= disk_port_pkg::ST_STAT;
            end
          end
        end
        disk_port_pkg::ST_STAT:
        begin
          if (data_rd)
          begin
            phase_r <= disk_port_pkg::ST_IDLE;
          end
        end
        default:
        begin
          phase_r <= disk_port_pkg::ST_RESET;
        end
      endcase
    end
  end

  // ==========================================================
  // Handshake flags
  always_ff @(posedge i_ref_clk)
  begin
    if (soft_reset)
    begin
      busy_r <= 1'b0;
      cd_r   <= 1'b0;
      io_r   <= 1'b0;
      req_r  <= 1'b0;
      irq_r  <= 1'b0;
      drq_r  <= 1'b0;
    end
    else
    begin
      case (phase_r)
        disk_port_pkg::ST_SELECT:
        begin
          busy_r <= 1'b1;
          cd_r   <= 1'b0;
        end
        disk_port_pkg::ST_CMD:
        begin
          if (req_r && data_wr)
          begin
            req_r <= 1'b0;
          end
          else if (!job_wait_r && !req_r)
          begin
            req_r <= 1'b1;
          end
          if (job_wait_r && i_job_valid)
          begin
            cd_r <= (i_job.count != '0);
            io_r <= i_job.to_host;
          end
        end
        disk_port_pkg::ST_DATA:
        begin
          if (byte_done)
          begin
            req_r <= 1'b0;
            drq_r <= 1'b0;
          end
          else if (data_avail && !req_r && !drq_r)
          begin
            req_r <= !dma_mode;
            drq_r <= dma_mode;
          end
        end
        disk_port_pkg::ST_STAT:
        begin
          // Completion read drops cd, io, busy, req and irq on the edge that leaves
          cd_r   <= !data_rd;
          io_r   <= !data_rd;
          busy_r <= !data_rd;
          req_r  <= irq_en && !data_rd;
          irq_r  <= irq_en && !data_rd;
        end
        default:
        begin
          req_r <= 1'b0;
          drq_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Data-in register
  always_ff @(posedge i_ref_clk)
  begin
    if (soft_reset)
    begin
      data_in_r <= disk_port_pkg::BYTE_ZERO;
    end
    else if (phase_r == disk_port_pkg::ST_STAT)
    begin
      data_in_r <= disk_port_pkg::BYTE_ZERO;
      data_in_r[disk_port_pkg::CB_LUN] <= lun_r;
      data_in_r[disk_port_pkg::CB_ERR] <= err_r;
    end
    else if (phase_r == disk_port_pkg::ST_DATA && io_r && data_avail && !req_r && !drq_r)
    begin
      data_in_r <= i_rd_data;
    end
  end

  // ==========================================================
  // Command byte pass-through
  always_ff @(posedge i_ref_clk)
  begin
    if (soft_reset)
    begin
      cmd_valid_r <= 1'b0;
      cmd_byte_r  <= disk_port_pkg::BYTE_ZERO;
    end
    else
    begin
      cmd_valid_r <= (phase_r == disk_port_pkg::ST_CMD) && req_r && data_wr;
      if ((phase_r == disk_port_pkg::ST_CMD) && req_r && data_wr)
      begin
        cmd_byte_r <= i_host.wdata;
      end
    end
  end

  // ==========================================================
  // Read mux, registered; answer one cycle after the read strobe
  function automatic logic [7:0] read_mux(input logic [9:0] a);
    case (a)
      disk_port_pkg::PORT_DATA:   read_mux = data_in_r;
      disk_port_pkg::PORT_STATUS: read_mux = {disk_port_pkg::STATUS_ONES,
                                              irq_r,
                                              drq_r && dma_mode,
                                              busy_r, cd_r, io_r, req_r};
      disk_port_pkg::PORT_CONFIG: read_mux = {disk_port_pkg::CONFIG_ONES,
                                              i_config_jumper};
      default:                    read_mux = disk_port_pkg::BYTE_ZERO;
    endcase
  endfunction

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      rdata_r <= disk_port_pkg::BYTE_ZERO;
    end
    else if (i_host.rd)
    begin
      rdata_r <= read_mux(i_host.addr);
    end
  end

  assign o_rdata     = rdata_r;
  assign o_drq       = drq_r && dma_mode;
  assign o_irq       = irq_r;
  assign o_phase     = phase_r;
  assign o_cmd_valid = cmd_valid_r;
  assign o_cmd_byte  = cmd_byte_r;
endmodule

// file: disk_ctrl_host_port_sva.sv
// Concurrent checks on the pins of the disk controller host port.
// Assumes one clock domain and a synchronous active-high reset.
module disk_ctrl_host_port_sva #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_srst,
  // Host bus and answers
  input  wire disk_port_pkg::host_req_s i_host,
  input  wire logic [7:0]               o_rdata,
  input  wire logic                     o_drq,
  input  wire logic                     i_dack,
  input  wire logic                     o_irq,
  input  wire logic [3:0]               i_config_jumper,
  input  wire disk_port_pkg::phase_e    o_phase
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Decoded strobes
  logic rd_st;
  logic rd_cfg;
  logic rd_dat;
  logic wr_rst;
  logic wr_sel;
  assign rd_st  = i_host.rd && (i_host.addr == disk_port_pkg::PORT_STATUS);
  assign rd_cfg = i_host.rd && (i_host.addr == disk_port_pkg::PORT_CONFIG);
  assign rd_dat = i_host.rd && (i_host.addr == disk_port_pkg::PORT_DATA);
  assign wr_rst = i_host.wr && (i_host.addr == disk_port_pkg::PORT_STATUS);
  assign wr_sel = i_host.wr && (i_host.addr == disk_port_pkg::PORT_CONFIG);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  // ==========================================================
  // Properties
  chk_status_ones: assert property (rd_st |=> o_rdata[7:6] == 2'h3)
    else $error("status top bits not ones");
  chk_status_dma: assert property (rd_st |=> o_rdata[4] == $past(o_drq))
    else $error("status dma flag differs from request pin");
  chk_config_read: assert property (rd_cfg |=> o_rdata == {4'hF, $past(i_config_jumper)})
    else $error("configuration byte wrong");
  chk_select_take: assert property ((wr_sel && o_phase == disk_port_pkg::ST_IDLE)
    |=> o_phase == disk_port_pkg::ST_SELECT)
    else $error("select in idle not taken");
  chk_select_skip: assert property ((wr_sel && o_phase != disk_port_pkg::ST_IDLE)
    |=> o_phase != disk_port_pkg::ST_SELECT)
    else $error("select outside idle taken");
  chk_busy_advance: assert property ((o_phase == disk_port_pkg::ST_SELECT && !wr_rst)
    |=> o_phase == disk_port_pkg::ST_CMD)
    else $error("selection did not advance");
  chk_port_reset: assert property (wr_rst |=> (o_phase == disk_port_pkg::ST_RESET
    && !o_drq && !o_irq) ##1 o_phase == disk_port_pkg::ST_IDLE)
    else $error("reset write not honoured");
  chk_drq_ack: assert property ((o_drq && i_dack) |=> !o_drq)
    else $error("request stayed after acknowledge");
  chk_irq_phase: assert property (o_irq |-> o_phase == disk_port_pkg::ST_STAT)
    else $error("interrupt outside status phase");
  chk_drq_phase: assert property (o_drq |-> o_phase == disk_port_pkg::ST_DATA)
    else $error("dma request outside data phase");
  chk_done_read: assert property ((rd_dat && o_phase == disk_port_pkg::ST_STAT)
    |=> (o_phase == disk_port_pkg::ST_IDLE && !o_irq))
    else $error("completion read did not return to idle");

  cover property (o_drq && i_dack);
  cover property (o_irq);
  cover property (wr_sel && o_phase == disk_port_pkg::ST_IDLE);
endmodule

// file: dma_responder.sv
// DMA controller model: answers each request with one acknowledge.
// Assumes requests are levels launched on rising edges of i_ref_clk.
module dma_responder (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // Request and pacing
  input  wire logic       i_drq,
  input  wire logic [3:0] i_wait,
  // Acknowledge and byte
  output logic            o_dack,
  output logic [7:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] next_r;

  initial
  begin
    o_dack = 1'b0;
    o_data = 8'hFF;
    next_r = 8'hA0;
    forever
    begin
      @(posedge i_ref_clk);
      if (i_drq && !i_srst)
      begin
        repeat (i_wait) @(posedge i_ref_clk);
        #1;
        o_dack = 1'b1;
        o_data = next_r;
        @(posedge i_ref_clk);
        #1;
        o_dack = 1'b0;
        // Released bus shows no stale byte
        o_data = ~next_r;
        next_r = next_r + 8'h01;
      end
    end
  end
endmodule

// file: tb_disk_ctrl_host_port.sv
// Self-checking bench for the disk controller host port.
// Assumes the checker and the DMA model are compiled before it.
module tb_disk_ctrl_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk = 1'b0;
  logic                      srst = 1'b1;
  disk_port_pkg::host_req_s  host = '0;
  disk_port_pkg::job_s       job = '0;
  disk_port_pkg::phase_e     phase;
  logic                      job_valid = 1'b0;
  logic                      wr_ready = 1'b1;
  logic [3:0]                dma_wait = 4'h1;
  logic [3:0]                jumpers = 4'hA;
  logic [7:0]                rd_src = 8'h50;
  logic [7:0]                rdata, dma_data, wr_data, cmd_byte, rv;
  logic                      drq, dack, irq, cmd_valid, wr_valid, rd_ready;
  logic [7:0]                cmd_q[$];
  logic [7:0]                wr_q[$];
  int                        errors = 0;
  int                        num_checks = 0;

  always #12.5 clk = ~clk;

  disk_ctrl_host_port #(
    .FIFO_DEPTH(4)
  ) dut (
    .i_ref_clk(clk), .i_srst(srst), .i_host(host), .o_rdata(rdata),
    .o_drq(drq), .i_dack(dack), .i_dma_wdata(dma_data), .o_irq(irq),
    .i_config_jumper(jumpers), .i_job_valid(job_valid), .i_job(job),
    .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte), .o_wr_valid(wr_valid),
    .o_wr_data(wr_data), .i_wr_ready(wr_ready), .i_rd_valid(1'b1),
    .i_rd_data(rd_src), .o_rd_ready(rd_ready), .o_phase(phase)
  );

  dma_responder u_dma (
    .i_ref_clk(clk), .i_srst(srst), .i_drq(drq), .i_wait(dma_wait),
    .o_dack(dack), .o_data(dma_data)
  );

  // ==========================================================
  // Back-end monitors and byte source
  always @(posedge clk)
  begin
    if (cmd_valid)
      cmd_q.push_back(cmd_byte);
    if (wr_valid && wr_ready)
      wr_q.push_back(wr_data);
    if (rd_ready)
      rd_src <= #1 rd_src + 8'h01;
  end

  // ==========================================================
  // Tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One strobe cycle; read data lands on the strobe's edge
  task automatic bus(input logic rd, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    host = '{rd: rd, wr: !rd, addr: a, wdata: d};
    @(posedge clk);
    #1;
    host = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    rv = rdata;
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
    while (rv[0] !== 1'b1 && n < 100)
    begin
      bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
      n++;
    end
    check("req wait", 8'(rv[0]), 8'h01);
  endtask

  task automatic wait_phase(input disk_port_pkg::phase_e p);
    int n;
    n = 0;
    while (phase !== p && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("phase", 8'(phase), 8'(p));
  endtask

  task automatic command(input int len, input logic [7:0] first);
    job_valid = 1'b1;
    bus(1'b0, disk_port_pkg::PORT_CONFIG, 8'h00);
    wait_req();
    check("cmd status", rv & 8'hFB, 8'hC9);
    bus(1'b0, disk_port_pkg::PORT_CONFIG, 8'h00);
    check("select in cmd", 8'(phase), 8'(disk_port_pkg::ST_CMD));
    for (int i = 0; i < len; i++)
    begin
      wait_req();
      bus(1'b0, disk_port_pkg::PORT_DATA, first + 8'(i));
    end
  endtask

  task automatic check_cmd(input int len, input logic [7:0] first);
    check("cmd count", 8'(cmd_q.size()), 8'(len));
    foreach (cmd_q[k])
      check("cmd byte", cmd_q[k], first + 8'(k));
    cmd_q.delete();
  endtask

  task automatic summarize();
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, sized well above the whole sequence
  initial
  begin
    #(25 * 20000);
    errors++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
    check("reset status", rv, 8'hC0);
    bus(1'b1, disk_port_pkg::PORT_CONFIG, 8'h00);
    check("config", rv, 8'hFA);
    bus(1'b1, disk_port_pkg::PORT_MASK, 8'h00);
    check("mask read", rv, 8'h00);
    // PIO read to host, interrupt enabled
    job = '{to_host: 1'b1, count: 16'h0003, lun: 1'b1, error: 1'b1};
    bus(1'b0, disk_port_pkg::PORT_MASK, 8'h02);
    command(6, 8'h08);
    wait_phase(disk_port_pkg::ST_DATA);
    job_valid = 1'b0;
    check_cmd(6, 8'h08);
    for (int i = 0; i < 3; i++)
    begin
      wait_req();
      check("pio status", rv, 8'hCF);
      bus(1'b1, disk_port_pkg::PORT_DATA, 8'h00);
      check("pio data", rv, 8'h50 + 8'(i));
    end
    wait_req();
    check("done status", rv, 8'hEF);
    check("irq on", 8'(irq), 8'h01);
    bus(1'b1, disk_port_pkg::PORT_DATA, 8'h00);
    check("completion", rv, 8'h22);
    bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
    check("idle status", rv, 8'hC0);
    check("irq off", 8'(irq), 8'h00);
    // DMA write with a slow acknowledge and a stalled buffer
    job = '{to_host: 1'b0, count: 16'h0006, lun: 1'b0, error: 1'b0};
    wr_ready = 1'b0;
    dma_wait = 4'h6;
    bus(1'b0, disk_port_pkg::PORT_MASK, 8'h01);
    command(10, 8'h20);
    wait_phase(disk_port_pkg::ST_DATA);
    job_valid = 1'b0;
    check_cmd(10, 8'h20);
    repeat (30) bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
    check("stall phase", 8'(phase), 8'(disk_port_pkg::ST_DATA));
    check("stall drq", 8'(drq), 8'h00);
    wr_ready = 1'b1;
    wait_phase(disk_port_pkg::ST_STAT);
    repeat (10) @(posedge clk);
    check("dma count", 8'(wr_q.size()), 8'h06);
    foreach (wr_q[k])
      check("dma byte", wr_q[k], 8'hA0 + 8'(k));
    bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
    check("dma done status", rv, 8'hCE);
    check("irq masked", 8'(irq), 8'h00);
    bus(1'b1, disk_port_pkg::PORT_DATA, 8'h00);
    check("completion", rv, 8'h00);
    wait_phase(disk_port_pkg::ST_IDLE);
    // Reset write in mid-command
    bus(1'b0, disk_port_pkg::PORT_CONFIG, 8'h00);
    wait_req();
    bus(1'b0, disk_port_pkg::PORT_STATUS, 8'h5A);
    check("reset phase", 8'(phase), 8'(disk_port_pkg::ST_RESET));
    bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
    check("after reset", rv, 8'hC0);
    // Command with no data phase, other jumper pattern
    job = '{to_host: 1'b0, count: 16'h0000, lun: 1'b1, error: 1'b0};
    jumpers = 4'h5;
    bus(1'b1, disk_port_pkg::PORT_CONFIG, 8'h00);
    check("config alt", rv, 8'hF5);
    command(6, 8'h00);
    wait_phase(disk_port_pkg::ST_STAT);
    job_valid = 1'b0;
    check_cmd(6, 8'h00);
    bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
    check("nodata status", rv, 8'hCE);
    bus(1'b1, disk_port_pkg::PORT_DATA, 8'h00);
    check("nodata completion", rv, 8'h20);
    bus(1'b1, disk_port_pkg::PORT_STATUS, 8'h00);
    check("nodata idle", rv, 8'hC0);
    summarize();
  end
endmodule

bind disk_ctrl_host_port disk_ctrl_host_port_sva #(
  .FIFO_DEPTH(FIFO_DEPTH)
) u_sva (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_host(i_host), .o_rdata(o_rdata),
  .o_drq(o_drq), .i_dack(i_dack), .o_irq(o_irq),
  .i_config_jumper(i_config_jumper), .o_phase(o_phase)
);
